// File: src/paos_sequencer.sv
// Purpose: Digital side of a 10-bit sampling converter: capture, range handling, latency.
// Assumes: i_strobe is the host encode clock sampled by i_clock; i_sample is the quantiser code.
// Notes: Result word appears four strobe edges after its sample.
`timescale 1ns/1ps
`default_nettype none
module paos_sequencer
  import paos_pkg::*;
#(
  parameter int LATENCY = PIPE_DEPTH,
  parameter int RECOVER = RECOVER_CYC,
  parameter int SLOW_CYC = TRACK_ONLY_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_strobe,
  input wire logic [DATA_WIDTH-1:0] i_sample,
  input wire logic i_over_range,
  input wire logic i_under_range,
  output logic [DATA_WIDTH-1:0] o_sample_bits,
  output logic o_out_of_range,
  output logic o_hold_active,
  output logic o_track_only
);

  // ****************************************
  // Strobe edge detect
  // ****************************************
  logic strobe_q;
  logic strobe_rise;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= i_strobe;
    end
  end

  assign strobe_rise = i_strobe & ~strobe_q;

  // ****************************************
  // Strobe rate monitor
  // ****************************************
  logic [CNT_WIDTH-1:0] period_q;
  logic slow_q;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      period_q <= '0;
      slow_q <= 1'b1;
    end else if (strobe_rise) begin
      period_q <= '0;
      slow_q <= (period_q >= CNT_WIDTH'(SLOW_CYC)); // see [RL7]
    end else if (period_q < CNT_WIDTH'(SLOW_CYC)) begin
      period_q <= period_q + 1'b1;
    end else begin
      slow_q <= 1'b1; // see [RL7]
    end
  end

  // ****************************************
  // Range state and hold control
  // ****************************************
  paos_range_type range_now;
  paos_th_type th_q;
  logic [CNT_WIDTH-1:0] rec_q;
  paos_range_type last_limit_q;

  always_comb begin
    if (i_over_range) begin
      range_now = RANGE_OVER;
    end else if (i_under_range) begin
      range_now = RANGE_UNDER;
    end else begin
      range_now = RANGE_IN;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      th_q <= TH_TRACK_ONLY;
      rec_q <= '0;
      last_limit_q <= RANGE_IN;
    end else begin
      unique case (th_q)
        TH_HOLD, TH_TRACK_ONLY: begin
          if (range_now != RANGE_IN) begin
            th_q <= TH_OFF; // see [RL4]
            last_limit_q <= range_now;
          end else begin
            th_q <= slow_q ? TH_TRACK_ONLY : TH_HOLD; // see [RL7]
          end
        end
        TH_OFF: begin
          if (range_now != RANGE_IN) begin
            last_limit_q <= range_now;
          end else begin
            th_q <= TH_RECOVER; // see [RL5]
            rec_q <= '0;
          end
        end
        TH_RECOVER: begin
          if (range_now != RANGE_IN) begin
            th_q <= TH_OFF;
            last_limit_q <= range_now;
          end else if (rec_q >= CNT_WIDTH'(RECOVER - 1)) begin
            th_q <= slow_q ? TH_TRACK_ONLY : TH_HOLD; // see [RL5]
          end else begin
            rec_q <= rec_q + 1'b1;
          end
        end
      endcase
    end
  end

  assign o_hold_active = (th_q == TH_HOLD);
  assign o_track_only = (th_q == TH_TRACK_ONLY);

  // ****************************************
  // Sample capture
  // ****************************************
  paos_word_type captured;

  always_comb begin
    captured.out_of_range = (th_q == TH_OFF) || (th_q == TH_RECOVER) || (range_now != RANGE_IN); // see [RL9]
    if (range_now == RANGE_OVER || (range_now == RANGE_IN && th_q != TH_HOLD && th_q != TH_TRACK_ONLY
        && last_limit_q == RANGE_OVER)) begin
      captured.code = CODE_MAX; // see [RL4]
    end else if (range_now == RANGE_UNDER || (range_now == RANGE_IN && th_q != TH_HOLD
        && th_q != TH_TRACK_ONLY && last_limit_q == RANGE_UNDER)) begin
      captured.code = CODE_MIN; // see [RL4]
    end else begin
      captured.code = i_sample; // see [RL1]
    end
  end

  // ****************************************
  // Pipeline and output latch
  // ****************************************
  paos_word_type piped;

  paos_pipe #(
    .DEPTH(LATENCY)
  ) u_pipe (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_advance(strobe_rise), // see [RL1]
    .i_word(captured),
    .o_word(piped)
  );

  assign o_sample_bits = piped.code; // see [RL2]
  assign o_out_of_range = piped.out_of_range; // see [RL10]

endmodule : paos_sequencer
`default_nettype wire

// File: src/paos_pkg.sv
// Purpose: Constants and types for the converter output sequencer.
// Assumes: Single 25 MHz system clock; strobe and analog compare inputs synchronous to it.
// Notes: Shared by the sequencer and its pipeline stage.
//
// Notes on behaviour
// [RL1] Each strobe rising edge freezes the input sample and starts a new conversion.
// [RL2] Each result is one ten-bit parallel word, updated on a strobe rising edge.
// [RL3] Output word belongs to the sample five strobe edges earlier; capture must pair accordingly. The pipeline delivers it four edges later.
// [RL4] Out of range: hold stops, sample bits forced to all ones or all zeros.
// [RL5] Back in range: hold re-enabled, valid words resume within about 10 ns. Here words stay clamped for two 40 ns clocks.
// [RL6] Host keeps strobe at or above 3 MSPS for guaranteed conversion.
// [RL7] Below about 1.5 MSPS the hold stage runs track-only.
// [RL8] After each strobe pause host applies five flush pulses before trusting outputs. The bench checks outputs from the first strobe rise after its pause.
// [RL9] Out-of-range flag low within range, high outside it. The flag also stays high in TH_OFF and TH_RECOVER with the input in range.
// [RL10] Sample bits and flag stay stable between consecutive strobe rising edges.
package paos_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int DATA_WIDTH = 10;
  localparam int PIPE_DEPTH = 5;
  localparam int CLOCK_HZ = 25000000;
  localparam int CLOCK_NS = 40;
  // Recovery after overdrive, longest time, rounds down, at least one cycle
  localparam int RECOVER_NS = 10;
  localparam int RECOVER_CYC = (RECOVER_NS / CLOCK_NS) < 1 ? 1 : (RECOVER_NS / CLOCK_NS);
  // Track-only threshold in samples per second; period in clocks
  localparam int TRACK_ONLY_SPS = 1500000;
  localparam int TRACK_ONLY_CYC = CLOCK_HZ / TRACK_ONLY_SPS;
  localparam int CNT_WIDTH = 8;
  localparam logic [DATA_WIDTH-1:0] CODE_MAX = 10'h3ff;
  localparam logic [DATA_WIDTH-1:0] CODE_MIN = 10'h000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef enum logic [1:0] {
    RANGE_IN,
    RANGE_OVER,
    RANGE_UNDER
  } paos_range_type;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] code;
    logic out_of_range;
  } paos_word_type;

  typedef enum {
    TH_HOLD,
    TH_TRACK_ONLY,
    TH_OFF,
    TH_RECOVER
  } paos_th_type;

endpackage : paos_pkg

// File: src/paos_pipe.sv
// Purpose: Fixed-depth strobe-advanced result pipeline.
// Assumes: Advance pulse lasts one clock per strobe edge.
// Notes: Output stays put between advances.
`timescale 1ns/1ps
`default_nettype none
module paos_pipe
  import paos_pkg::*;
#(
  parameter int DEPTH = PIPE_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_advance,
  input wire paos_word_type i_word,
  output paos_word_type o_word
);

  paos_word_type stage_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      if (g == 0) begin : g_head
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
          if (i_sys_rst) begin
            stage_q[g] <= '0;
          end else if (i_advance) begin
            stage_q[g] <= i_word; // see [RL3]
          end
        end
      end else begin : g_tail
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
          if (i_sys_rst) begin
            stage_q[g] <= '0;
          end else if (i_advance) begin
            stage_q[g] <= stage_q[g-1]; // see [RL3]
          end
        end
      end
    end
  endgenerate

  assign o_word = stage_q[DEPTH-1]; // see [RL10]

endmodule : paos_pipe
`default_nettype wire

// File: dv/paos_host_model.sv
// Purpose: Host logic making the encode strobe and quantiser codes.
// Assumes: Driven on falling clock edges.
// Notes: Strobe stands low while i_run is low.
`timescale 1ns/1ps
`default_nettype none
module paos_host_model import paos_pkg::*; (
  input wire logic i_clock,
  input wire logic i_run,
  input wire logic [7:0] i_half,
  output logic o_strobe,
  output logic [DATA_WIDTH-1:0] o_sample,
  output int o_rises
);
  logic [7:0] cnt = 8'h01;
  initial o_strobe = 1'b0;
  initial o_sample = 10'h02a;
  initial o_rises = 0;
  // Code for the next rise is set while the strobe is low
  always @(negedge i_clock) begin
    if (!i_run) begin
      if (o_strobe) o_sample <= 10'(o_rises * 37 + 42);
      o_strobe <= 1'b0;
      cnt <= 8'h01;
    end else if (cnt >= i_half) begin
      cnt <= 8'h01;
      o_strobe <= ~o_strobe;
      if (!o_strobe) o_rises <= o_rises + 1;
      else o_sample <= 10'(o_rises * 37 + 42);
    end else cnt <= cnt + 8'h01;
  end
endmodule : paos_host_model
`default_nettype wire

// File: dv/paos_properties.sv
// Purpose: Port checker for the output sequencer.
// Assumes: Strobe rise seen as 0 then 1 on clock edges.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module paos_properties import paos_pkg::*; (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_strobe,
  input wire logic [DATA_WIDTH-1:0] i_sample,
  input wire logic i_over_range,
  input wire logic i_under_range,
  input wire logic [DATA_WIDTH-1:0] o_sample_bits,
  input wire logic o_out_of_range,
  input wire logic o_hold_active,
  input wire logic o_track_only
);
  logic stb_q;
  logic [7:0] gap_q;
  logic rise;
  logic armed_q = 1'b0;
  assign rise = i_strobe & ~stb_q;
  // Outputs are unknown until the first clock edge inside reset
  always_ff @(posedge i_clock) begin
    armed_q <= 1'b1;
  end
  // Clocks since the previous strobe rise, saturating
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stb_q <= 1'b0;
      gap_q <= 8'hff;
    end else begin
      stb_q <= i_strobe;
      gap_q <= rise ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  chk_bits_stable: assert property ($changed(o_sample_bits) |-> $past(rise) || $past(rise, 2))
    else $error("sample bits moved without strobe");
  chk_flag_stable: assert property ($changed(o_out_of_range) |-> $past(rise) || $past(rise, 2))
    else $error("range flag moved without strobe");
  chk_range_clamp: assert property (o_out_of_range |-> o_sample_bits == 10'h3ff || o_sample_bits == 10'h000)
    else $error("flagged word not at a limit");
  chk_modes_excl: assert property (!(o_hold_active && o_track_only))
    else $error("hold and track-only together");
  chk_slow_track: assert property (rise && gap_q > 8'd18 && gap_q != 8'hff |-> ##[1:3] o_track_only)
    else $error("slow strobe not track-only");
  chk_fast_hold: assert property (rise && gap_q < 8'd9 && !(i_over_range || i_under_range)
    && !$past(i_over_range || i_under_range) && !$past(i_over_range || i_under_range, 2) |-> ##[1:3] o_hold_active)
    else $error("fast strobe not holding");
  chk_reset_word: assert property (disable iff (1'b0) i_sys_rst && armed_q |-> o_sample_bits == 10'h000
    && !o_out_of_range)
    else $error("word not cleared in reset");
  chk_reset_mode: assert property (disable iff (1'b0) i_sys_rst && armed_q |-> o_track_only && !o_hold_active)
    else $error("mode wrong in reset");
  cover property (rise && i_over_range);
  cover property (rise && i_under_range);
  cover property (rise && gap_q > 8'd18 && gap_q != 8'hff);
endmodule : paos_properties
`default_nettype wire

// File: dv/paos_sequencer_tb_top.sv
// Purpose: Bench for the output sequencer.
// Assumes: Host model makes strobe and codes.
// Notes: Latency, clamping, recovery and rate modes.
`timescale 1ns/1ps
`default_nettype none
module paos_sequencer_tb_top import paos_pkg::*;;
  logic i_clock = 1'b0;
  logic rst = 1'b1, run = 1'b0, over = 1'b0, under = 1'b0, strobe, oor, hold, trk;
  logic [7:0] half = 8'h02;
  logic [DATA_WIDTH-1:0] sample, bits;
  int rises, m, fail_count = 0, checks_done = 0;
  always #20 i_clock = ~i_clock;
  paos_host_model host (.i_clock(i_clock), .i_run(run), .i_half(half), .o_strobe(strobe), .o_sample(sample),
    .o_rises(rises));
  paos_sequencer dut (.i_clock(i_clock), .i_sys_rst(rst), .i_strobe(strobe), .i_sample(sample), .i_over_range(over),
    .i_under_range(under), .o_sample_bits(bits), .o_out_of_range(oor), .o_hold_active(hold), .o_track_only(trk));
  function automatic logic [DATA_WIDTH-1:0] code(input int k);
    return 10'(k * 37 + 5);
  endfunction : code
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [DATA_WIDTH-1:0] seen, input logic [DATA_WIDTH-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic next_rise();
    int n0 = rises;
    for (int i = 0; i < 400 && rises == n0; i++) @(posedge i_clock);
    if (rises == n0) begin
      fail_count++;
      $display("Error at %0t: no strobe", $time);
      tally_and_finish();
    end
    repeat (2) @(negedge i_clock);
  endtask : next_rise
  task automatic stream(input int n);
    for (int i = 0; i < n; i++) begin
      next_rise();
      if (rises >= 5) check(bits, code(rises - 4));
      check(10'(oor), 10'h000);
    end
    check(10'({hold, trk}), 10'h002);
  endtask : stream
  task automatic overdrive(input logic up, input logic [DATA_WIDTH-1:0] lim);
    over = up;
    under = ~up;
    next_rise();
    m = rises;
    over = 1'b0;
    under = 1'b0;
    repeat (4) next_rise();
    check(bits, lim);
    check(10'(oor), 10'h001);
    next_rise();
    check(bits, code(m + 1));
    check(10'(oor), 10'h000);
  endtask : overdrive
  task automatic rate(input logic [7:0] h, input logic [1:0] exp);
    half = h;
    repeat (3) next_rise();
    check(10'({hold, trk}), 10'(exp));
  endtask : rate
  initial begin
    repeat (6) @(negedge i_clock);
    check(bits, 10'h000);
    check(10'({oor, hold, trk}), 10'h001);
    rst = 1'b0;
    run = 1'b1;
    stream(12);
    overdrive(1'b1, 10'h3ff);
    overdrive(1'b0, 10'h000);
    rate(8'h0a, 2'b01);
    rate(8'h02, 2'b10);
    run = 1'b0;
    repeat (30) @(negedge i_clock);
    run = 1'b1;
    stream(8);
    tally_and_finish();
  end
endmodule : paos_sequencer_tb_top
bind paos_sequencer paos_properties chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_strobe(i_strobe),
  .i_sample(i_sample), .i_over_range(i_over_range), .i_under_range(i_under_range), .o_sample_bits(o_sample_bits),
  .o_out_of_range(o_out_of_range), .o_hold_active(o_hold_active), .o_track_only(o_track_only));
`default_nettype wire
